// *** pkg/lpwd_consts.svh ***
// register offsets, field positions, reset values and timing counts of the wake-up detector
`ifndef LPWD_CONSTS_SVH
`define LPWD_CONSTS_SVH
`define LPWD_IDX_CMD 6'h01
`define LPWD_IDX_OP 6'h02
`define LPWD_IDX_CFG 6'h03
`define LPWD_IDX_IRQ 6'h1A
`define LPWD_IDX_AAT1 6'h21
`define LPWD_IDX_AAT2 6'h22
`define LPWD_IDX_ADC 6'h25
`define LPWD_IDX_CAPC 6'h2F
`define LPWD_IDX_CAPD 6'h30
`define LPWD_IDX_WUT 6'h32
`define LPWD_IDX_GRP_FIRST 6'h33
`define LPWD_IDX_GRP_LAST 6'h3E
`define LPWD_CMD_MEAS_CAP 8'h01
`define LPWD_CMD_CAL_CAP 8'h02
`define LPWD_OP_OSC_BIT 7
`define LPWD_OP_WU_ONLY 8'h04
`define LPWD_CFG_AAT_BIT 0
`define LPWD_WUT_RESET 8'h30
`define LPWD_WUT_SEL_MSB 6
`define LPWD_WUT_SEL_LSB 4
`define LPWD_MCFG_THR_MSB 7
`define LPWD_MCFG_THR_LSB 4
`define LPWD_MCFG_AUTO_BIT 3
`define LPWD_MCFG_W_MSB 2
`define LPWD_MCFG_W_LSB 1
`define LPWD_MCFG_INCL_BIT 0
`define LPWD_CAPD_CODE_MSB 7
`define LPWD_CAPD_CODE_LSB 3
`define LPWD_CAPD_DONE_BIT 1
`define LPWD_CAPD_ERR_BIT 0
`define LPWD_CAL_W 5
`define LPWD_CAL_STEP_FF 100
`define LPWD_CAL_RANGE_FF 3100
`define LPWD_CAL_SAT 8'hF8
`define LPWD_AAT_DEFAULT 8'h80
`define LPWD_REF_W 10
`define LPWD_RESP_OKAY 2'b00
`define LPWD_RESP_SLVERR 2'b10
`define LPWD_CLK_MHZ 250
`define LPWD_CAP_MEAS_US 200
`define LPWD_FIELD_ON_US 20
`define LPWD_CAP_MEAS_CYC (`LPWD_CAP_MEAS_US * `LPWD_CLK_MHZ)
`define LPWD_FIELD_ON_CYC (`LPWD_FIELD_ON_US * `LPWD_CLK_MHZ)
`define LPWD_RC_KHZ 32
`define LPWD_RC_DIV_CYC ((`LPWD_CLK_MHZ * 1000) / `LPWD_RC_KHZ)
`define LPWD_PER0_MS 10
`define LPWD_PER1_MS 20
`define LPWD_PER2_MS 50
`define LPWD_PER3_MS 100
`define LPWD_PER4_MS 200
`define LPWD_PER5_MS 300
`define LPWD_PER6_MS 400
`define LPWD_PER7_MS 800
`endif

// *** pkg/lpwd_pkg.sv ***
// types of the wake-up detector
package lpwd_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_AVG} lpwd_state_t;
	typedef struct packed {
		logic [9:0] ref_val;
		logic done;
	} lpwd_avg_t;
	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic aw_got;
		logic w_got;
		logic [5:0] aw_idx;
		logic [7:0] wd;
		logic wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] op;
		logic [7:0] cfg;
		logic [7:0] aat1;
		logic [7:0] aat2;
		logic [7:0] capc;
		logic [7:0] capd;
		logic [7:0] adc_out;
		logic [7:0] wut;
		logic [2:0] irq_stat;
		logic [2:0][7:0] mcfg;
		logic [2:0][7:0] mref;
		logic [2:0][9:0] avg;
		logic [2:0][7:0] last;
		logic [2:0] avg_ok;
		logic seeded;
		logic wake_d;
		logic [2:0] pend;
		lpwd_state_t st;
		logic [1:0] kind;
		logic cal;
		logic [15:0] cnt;
		logic [15:0] tick_cnt;
		logic [15:0] per_cnt;
		logic avg_go;
		logic [7:0] adc_s1;
		logic [7:0] adc_s2;
		logic excite;
		logic field;
		logic [7:0] aat_a;
		logic [7:0] aat_b;
		logic [4:0] cal_code;
		logic irq;
		logic wake;
	} lpwd_regs_t;
endpackage

// *** src/lpwd_avg.sv ***
// reference averaging step: new = old - (old - meas) / weight
`timescale 1ns/100ps
`include "lpwd_consts.svh"
module lpwd_avg (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [`LPWD_REF_W-1:0] old_ref_i,
	input wire logic [`LPWD_REF_W-1:0] meas_i,
	input wire logic [1:0] wsel_i,
	output logic [`LPWD_REF_W-1:0] ref_o,
	output logic done_o
);
	lpwd_pkg::lpwd_avg_t s_reg;
	lpwd_pkg::lpwd_avg_t s_next;
	logic signed [`LPWD_REF_W:0] diff;
	logic signed [`LPWD_REF_W:0] step;

	always_comb begin
		diff = $signed({1'b0, old_ref_i}) - $signed({1'b0, meas_i});
		step = diff >>> wsel_i;
		s_next = s_reg;
		s_next.done = start_i;
		if (start_i) begin
			s_next.ref_val = `LPWD_REF_W'($signed({1'b0, old_ref_i}) - step);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_reg <= '0;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign ref_o = s_reg.ref_val;
	assign done_o = s_reg.done;
endmodule

// *** src/lpwd_top.sv ***
// low-power wake-up detector with capacitive sensor sequencing and antenna tuning gate
`timescale 1ns/100ps
`include "lpwd_consts.svh"
module lpwd_top #(
	parameter int AW = 8,
	parameter int CAP_MEAS_CYC = `LPWD_CAP_MEAS_CYC,
	parameter int FIELD_ON_CYC = `LPWD_FIELD_ON_CYC,
	parameter int RC_DIV_CYC = `LPWD_RC_DIV_CYC
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic [AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [7:0] adc_data_i,
	output logic excite_electrode_o,
	output logic field_driver_out_o,
	output logic [4:0] cal_code_o,
	output logic [7:0] aat_a_o,
	output logic [7:0] aat_b_o,
	output logic irq_o,
	output logic wake_active_o
);
	if (AW < 8 || CAP_MEAS_CYC < 1 || CAP_MEAS_CYC > 65536 || FIELD_ON_CYC < 1
		|| FIELD_ON_CYC > 65536 || RC_DIV_CYC < 1 || RC_DIV_CYC > 65536) begin : g_bad_param
		$error("lpwd_top: parameter out of range");
	end

	lpwd_pkg::lpwd_regs_t s_reg;
	lpwd_pkg::lpwd_regs_t s_next;
	logic [9:0] avg_ref_w;
	logic avg_done_w;

	// group decode: {hit, method, slot}
	function automatic logic [4:0] grp_dec(input logic [5:0] idx);
		logic [5:0] off;
		off = idx - `LPWD_IDX_GRP_FIRST;
		if (idx >= `LPWD_IDX_GRP_FIRST && idx <= `LPWD_IDX_GRP_LAST) begin
			grp_dec = {1'b1, off[3:2], off[1:0]};
		end else begin
			grp_dec = 5'h00;
		end
	endfunction

	function automatic logic [8:0] rd_reg(input lpwd_pkg::lpwd_regs_t r, input logic [5:0] idx);
		logic [4:0] g;
		g = grp_dec(idx);
		if (idx == `LPWD_IDX_CMD) begin
			rd_reg = {1'b1, 8'h00};
		end else if (idx == `LPWD_IDX_OP) begin
			rd_reg = {1'b1, r.op};
		end else if (idx == `LPWD_IDX_CFG) begin
			rd_reg = {1'b1, r.cfg};
		end else if (idx == `LPWD_IDX_IRQ) begin
			rd_reg = {1'b1, 5'h00, r.irq_stat};
		end else if (idx == `LPWD_IDX_AAT1) begin
			rd_reg = {1'b1, r.aat1};
		end else if (idx == `LPWD_IDX_AAT2) begin
			rd_reg = {1'b1, r.aat2};
		end else if (idx == `LPWD_IDX_ADC) begin
			rd_reg = {1'b1, r.adc_out};
		end else if (idx == `LPWD_IDX_CAPC) begin
			rd_reg = {1'b1, r.capc};
		end else if (idx == `LPWD_IDX_CAPD) begin
			rd_reg = {1'b1, r.capd};
		end else if (idx == `LPWD_IDX_WUT) begin
			rd_reg = {1'b1, r.wut};
		end else if (g[4] && g[1:0] == 2'h0) begin
			rd_reg = {1'b1, r.mcfg[g[3:2]]};
		end else if (g[4] && g[1:0] == 2'h1) begin
			rd_reg = {1'b1, r.mref[g[3:2]]};
		end else if (g[4] && g[1:0] == 2'h2) begin
			rd_reg = {1'b1, r.avg[g[3:2]][9:2]};
		end else if (g[4]) begin
			rd_reg = {1'b1, r.last[g[3:2]]};
		end else begin
			rd_reg = 9'h000;
		end
	endfunction

	function automatic logic [15:0] per_ticks(input logic [2:0] sel);
		case (sel)
			3'h0: per_ticks = 16'(`LPWD_PER0_MS * `LPWD_RC_KHZ);
			3'h1: per_ticks = 16'(`LPWD_PER1_MS * `LPWD_RC_KHZ);
			3'h2: per_ticks = 16'(`LPWD_PER2_MS * `LPWD_RC_KHZ);
			3'h3: per_ticks = 16'(`LPWD_PER3_MS * `LPWD_RC_KHZ);
			3'h4: per_ticks = 16'(`LPWD_PER4_MS * `LPWD_RC_KHZ);
			3'h5: per_ticks = 16'(`LPWD_PER5_MS * `LPWD_RC_KHZ);
			3'h6: per_ticks = 16'(`LPWD_PER6_MS * `LPWD_RC_KHZ);
			default: per_ticks = 16'(`LPWD_PER7_MS * `LPWD_RC_KHZ);
		endcase
	endfunction

	function automatic logic [7:0] mag(input logic [7:0] a, input logic [7:0] b);
		mag = (a > b) ? a - b : b - a;
	endfunction

	lpwd_avg u_avg (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.start_i(s_reg.avg_go),
		.old_ref_i(s_reg.avg[s_reg.kind]),
		.meas_i({s_reg.last[s_reg.kind], 2'b00}),
		.wsel_i(s_reg.mcfg[s_reg.kind][`LPWD_MCFG_W_MSB:`LPWD_MCFG_W_LSB]),
		.ref_o(avg_ref_w),
		.done_o(avg_done_w)
	);

	always_comb begin
		logic wr_go;
		logic cmd_meas;
		logic cmd_cal;
		logic wake;
		logic fire;
		logic hit;
		logic [1:0] m;
		logic [7:0] r;
		logic [7:0] refv;
		logic [4:0] g;
		logic [8:0] rd;
		wr_go = 1'b0;
		cmd_meas = 1'b0;
		cmd_cal = 1'b0;
		fire = 1'b0;
		hit = 1'b0;
		m = 2'h0;
		r = s_reg.adc_s2;
		refv = 8'h00;
		g = grp_dec(s_reg.aw_idx);
		rd = 9'h000;
		s_next = s_reg;
		s_next.avg_go = 1'b0;
		s_next.adc_s1 = adc_data_i;
		s_next.adc_s2 = s_reg.adc_s1;
		wake = (s_reg.op == `LPWD_OP_WU_ONLY);

		// write channel
		if (s_reg.aw_rdy && s_axi_awvalid_i) begin
			s_next.aw_got = 1'b1;
			s_next.aw_idx = s_axi_awaddr_i[7:2];
		end
		if (s_reg.w_rdy && s_axi_wvalid_i) begin
			s_next.w_got = 1'b1;
			s_next.wd = s_axi_wdata_i[7:0];
			s_next.wstb = s_axi_wstrb_i[0];
		end
		if (s_reg.bvalid && s_axi_bready_i) begin
			s_next.bvalid = 1'b0;
		end
		wr_go = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
		if (wr_go) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			rd = rd_reg(s_reg, s_reg.aw_idx);
			s_next.bresp = rd[8] ? `LPWD_RESP_OKAY : `LPWD_RESP_SLVERR;
			if (s_reg.wstb) begin
				if (s_reg.aw_idx == `LPWD_IDX_CMD) begin
					cmd_meas = (s_reg.wd == `LPWD_CMD_MEAS_CAP);
					cmd_cal = (s_reg.wd == `LPWD_CMD_CAL_CAP);
				end else if (s_reg.aw_idx == `LPWD_IDX_OP) begin
					s_next.op = s_reg.wd;
				end else if (s_reg.aw_idx == `LPWD_IDX_CFG) begin
					s_next.cfg = s_reg.wd;
				end else if (s_reg.aw_idx == `LPWD_IDX_IRQ) begin
					s_next.irq_stat = s_reg.irq_stat & ~s_reg.wd[2:0];
				end else if (s_reg.aw_idx == `LPWD_IDX_AAT1) begin
					s_next.aat1 = s_reg.wd;
				end else if (s_reg.aw_idx == `LPWD_IDX_AAT2) begin
					s_next.aat2 = s_reg.wd;
				end else if (s_reg.aw_idx == `LPWD_IDX_CAPC) begin
					s_next.capc = s_reg.wd;
				end else if (s_reg.aw_idx == `LPWD_IDX_WUT) begin
					s_next.wut = s_reg.wd;
				end else if (g[4] && g[1:0] == 2'h0) begin
					s_next.mcfg[g[3:2]] = s_reg.wd;
				end else if (g[4] && g[1:0] == 2'h1) begin
					s_next.mref[g[3:2]] = s_reg.wd;
				end
			end
		end
		s_next.aw_rdy = !s_next.aw_got && !s_next.bvalid;
		s_next.w_rdy = !s_next.w_got && !s_next.bvalid;

		// read channel
		if (s_reg.rvalid && s_axi_rready_i) begin
			s_next.rvalid = 1'b0;
		end
		if (s_reg.ar_rdy && s_axi_arvalid_i) begin
			rd = rd_reg(s_reg, s_axi_araddr_i[7:2]);
			s_next.rvalid = 1'b1;
			s_next.rdata = {24'h000000, rd[7:0]};
			s_next.rresp = rd[8] ? `LPWD_RESP_OKAY : `LPWD_RESP_SLVERR;
		end
		s_next.ar_rdy = !s_next.rvalid;

		// wake-up entry and 32 kHz period timer
		s_next.wake_d = wake;
		if (wake && !s_reg.wake_d && !s_reg.seeded) begin
			s_next.seeded = 1'b1;
			for (int i = 0; i < 3; i++) begin
				if (s_reg.mref[i] != 8'h00) begin
					s_next.avg[i] = {s_reg.mref[i], 2'b00};
					s_next.avg_ok[i] = 1'b1;
				end
			end
		end
		if (wake && s_reg.wake_d) begin
			s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;
			if (s_reg.tick_cnt == 16'(RC_DIV_CYC - 1)) begin
				s_next.tick_cnt = 16'h0000;
				s_next.per_cnt = s_reg.per_cnt + 16'h0001;
				if (s_reg.per_cnt == per_ticks(s_reg.wut[`LPWD_WUT_SEL_MSB:`LPWD_WUT_SEL_LSB]) - 16'h0001) begin
					s_next.per_cnt = 16'h0000;
					fire = 1'b1;
				end
			end
		end else begin
			s_next.tick_cnt = 16'h0000;
			s_next.per_cnt = 16'h0000;
		end

		// measurement sequencer
		case (s_reg.st)
			lpwd_pkg::ST_IDLE: begin
				if (wake && s_reg.pend != 3'h0) begin
					m = s_reg.pend[0] ? 2'h0 : (s_reg.pend[1] ? 2'h1 : 2'h2);
					s_next.pend[m] = 1'b0;
					s_next.cal = 1'b0;
				end else if (!wake && (cmd_meas || cmd_cal)) begin
					m = 2'h2;
					s_next.cal = cmd_cal;
				end else begin
					m = 2'h3;
				end
				if (m != 2'h3) begin
					s_next.st = lpwd_pkg::ST_MEAS;
					s_next.kind = m;
					s_next.excite = (m == 2'h2);
					s_next.field = (m != 2'h2);
					s_next.cnt = (m == 2'h2) ? 16'(CAP_MEAS_CYC - 1) : 16'(FIELD_ON_CYC - 1);
				end
			end
			lpwd_pkg::ST_MEAS: begin
				if (s_reg.cnt != 16'h0000) begin
					s_next.cnt = s_reg.cnt - 16'h0001;
				end else begin
					s_next.excite = 1'b0;
					s_next.field = 1'b0;
					s_next.st = lpwd_pkg::ST_IDLE;
					s_next.adc_out = r;
					s_next.last[s_reg.kind] = r;
					if (s_reg.cal) begin
						s_next.capd[`LPWD_CAPD_DONE_BIT] = 1'b1;
						s_next.capd[`LPWD_CAPD_ERR_BIT] = (r >= `LPWD_CAL_SAT);
						s_next.capd[`LPWD_CAPD_CODE_MSB:`LPWD_CAPD_CODE_LSB] = r[7:3];
						s_next.capc[`LPWD_CAL_W-1:0] = r[7:3];
					end else if (wake) begin
						refv = s_reg.mcfg[s_reg.kind][`LPWD_MCFG_AUTO_BIT] ?
							s_reg.avg[s_reg.kind][9:2] : s_reg.mref[s_reg.kind];
						hit = mag(r, refv) > {4'h0,
							s_reg.mcfg[s_reg.kind][`LPWD_MCFG_THR_MSB:`LPWD_MCFG_THR_LSB]};
						if (s_reg.mcfg[s_reg.kind][`LPWD_MCFG_AUTO_BIT]) begin
							if (!s_reg.avg_ok[s_reg.kind]) begin
								hit = 1'b0;
								s_next.avg[s_reg.kind] = {r, 2'b00};
								s_next.avg_ok[s_reg.kind] = 1'b1;
							end else if (!hit || s_reg.mcfg[s_reg.kind][`LPWD_MCFG_INCL_BIT]) begin
								s_next.avg_go = 1'b1;
								s_next.st = lpwd_pkg::ST_AVG;
							end
						end
						if (hit) begin
							s_next.irq_stat[s_reg.kind] = 1'b1;
						end
					end
				end
			end
			lpwd_pkg::ST_AVG: begin
				if (avg_done_w) begin
					s_next.avg[s_reg.kind] = avg_ref_w;
					s_next.st = lpwd_pkg::ST_IDLE;
				end
			end
			default: begin
				s_next.st = lpwd_pkg::ST_IDLE;
			end
		endcase
		if (!wake) begin
			s_next.pend = 3'h0;
		end else if (fire && s_reg.st == lpwd_pkg::ST_IDLE && s_reg.pend == 3'h0) begin
			s_next.pend = s_reg.wut[2:0];
		end

		// antenna tuning gate
		if (s_reg.cfg[`LPWD_CFG_AAT_BIT] && s_reg.op[`LPWD_OP_OSC_BIT]) begin
			s_next.aat_a = s_reg.aat1;
			s_next.aat_b = s_reg.aat2;
		end else if (s_reg.cfg[`LPWD_CFG_AAT_BIT]) begin
			s_next.aat_a = `LPWD_AAT_DEFAULT;
			s_next.aat_b = `LPWD_AAT_DEFAULT;
		end else begin
			s_next.aat_a = 8'h00;
			s_next.aat_b = 8'h00;
		end
		// compensation released during auto calibration
		s_next.cal_code = (s_next.st == lpwd_pkg::ST_MEAS && s_next.cal) ?
			5'h00 : s_next.capc[`LPWD_CAL_W-1:0];
		s_next.irq = |s_next.irq_stat;
		s_next.wake = wake;
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_reg <= '0;
			s_reg.wut <= `LPWD_WUT_RESET;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready_o = s_reg.aw_rdy;
	assign s_axi_wready_o = s_reg.w_rdy;
	assign s_axi_bresp_o = s_reg.bresp;
	assign s_axi_bvalid_o = s_reg.bvalid;
	assign s_axi_arready_o = s_reg.ar_rdy;
	assign s_axi_rdata_o = s_reg.rdata;
	assign s_axi_rresp_o = s_reg.rresp;
	assign s_axi_rvalid_o = s_reg.rvalid;
	assign excite_electrode_o = s_reg.excite;
	assign field_driver_out_o = s_reg.field;
	assign cal_code_o = s_reg.cal_code;
	assign aat_a_o = s_reg.aat_a;
	assign aat_b_o = s_reg.aat_b;
	assign irq_o = s_reg.irq;
	assign wake_active_o = s_reg.wake;
endmodule

// *** sim/lpwd_top_sva.sv ***
// port-level assertion checker for the wake-up detector
`timescale 1ns/100ps
module lpwd_top_sva #(
	parameter int CAP_MEAS_CYC = 20,
	parameter int FIELD_ON_CYC = 10
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic excite_electrode_o,
	input wire logic field_driver_out_o,
	input wire logic [7:0] aat_a_o,
	input wire logic [7:0] aat_b_o,
	input wire logic irq_o,
	input wire logic wake_active_o
);
	logic [15:0] exc_cnt_reg;
	logic [15:0] fld_cnt_reg;
	// high-time counters of the two drive outputs
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			exc_cnt_reg <= 16'h0000;
			fld_cnt_reg <= 16'h0000;
		end else begin
			exc_cnt_reg <= excite_electrode_o ? exc_cnt_reg + 16'h0001 : 16'h0000;
			fld_cnt_reg <= field_driver_out_o ? fld_cnt_reg + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	property p_tune_wake;
		wake_active_o && $past(wake_active_o) |->
			aat_a_o == aat_b_o && (aat_a_o == 8'h80 || aat_a_o == 8'h00);
	endproperty
	a_tune_wake: assert property (p_tune_wake) else $error("tuning level wrong");
	property p_exc_len;
		$fell(excite_electrode_o) |-> exc_cnt_reg == 16'(CAP_MEAS_CYC);
	endproperty
	a_exc_len: assert property (p_exc_len) else $error("excite length wrong");
	property p_fld_len;
		$fell(field_driver_out_o) |-> fld_cnt_reg == 16'(FIELD_ON_CYC);
	endproperty
	a_fld_len: assert property (p_fld_len) else $error("field length wrong");
	property p_fld_wake;
		$rose(field_driver_out_o) |-> wake_active_o;
	endproperty
	a_fld_wake: assert property (p_fld_wake) else $error("field outside wake-up");
	property p_one_drive;
		!(excite_electrode_o && field_driver_out_o);
	endproperty
	a_one_drive: assert property (p_one_drive) else $error("two methods at once");
	property p_irq_cause;
		$rose(irq_o) |-> $fell(excite_electrode_o) || $fell(field_driver_out_o);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without measurement");
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_lat;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |->
			##2 s_axi_bvalid_o;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	property p_r_lat;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read response late");
	c_irq: cover property ($rose(irq_o));
	c_field: cover property ($fell(field_driver_out_o));
	c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'b10);
endmodule
bind lpwd_top lpwd_top_sva #(.CAP_MEAS_CYC(CAP_MEAS_CYC), .FIELD_ON_CYC(FIELD_ON_CYC))
	lpwd_top_sva_i (.clk_sys_i, .srst_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.excite_electrode_o, .field_driver_out_o, .aat_a_o, .aat_b_o, .irq_o, .wake_active_o);

// *** sim/lpwd_analog_model.sv ***
// analog side model: electrodes, field sensing and converter output
`timescale 1ns/100ps
module lpwd_analog_model (
	input wire logic excite_i,
	input wire logic field_i,
	input wire logic [7:0] level_i,
	output logic [7:0] adc_data_o
);
	// converted sensor level while excited or field driven, inverted when idle
	assign adc_data_o = (excite_i || field_i) ? level_i : ~level_i;
endmodule

// *** sim/tb_top.sv ***
// self-checking testbench of the wake-up detector
`timescale 1ns/100ps
`include "lpwd_consts.svh"
module tb_top;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [7:0] level = 8'h00;
	logic awready, wready, bvalid, arready, rvalid, excite, field, irq, wake;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [31:0] rdata;
	logic [7:0] adc;
	logic [4:0] cal_code;
	logic [7:0] aat_a;
	logic [7:0] aat_b;
	int num_errors = 0;
	int checked = 0;
	always #2 clk_sys = ~clk_sys;
	lpwd_top #(.CAP_MEAS_CYC(20), .FIELD_ON_CYC(10), .RC_DIV_CYC(4)) lpwd_top_i (
		.clk_sys_i(clk_sys), .srst_i(srst), .ce_i(1'b1),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .adc_data_i(adc),
		.excite_electrode_o(excite), .field_driver_out_o(field), .cal_code_o(cal_code),
		.aat_a_o(aat_a), .aat_b_o(aat_b), .irq_o(irq), .wake_active_o(wake));
	lpwd_analog_model lpwd_analog_model_i (.excite_i(excite), .field_i(field),
		.level_i(level), .adc_data_o(adc));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 200);
		bready <= 1'b0;
		chk({7'h00, bvalid}, 8'h01, "write answer");
		chk({6'h00, bresp}, {6'h00, er}, "write response");
	endtask
	task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_sys);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 200);
		rready <= 1'b0;
		chk({7'h00, rvalid}, 8'h01, "read answer");
		chk({6'h00, rresp}, {6'h00, er}, "read response");
		if (er == `LPWD_RESP_OKAY) chk(rdata[7:0], exp, "read data");
	endtask
	task automatic wait_meas;
		int n;
		n = 0;
		while (excite !== 1'b1 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		while (excite !== 1'b0 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 4000) begin
			num_errors++;
			$display("unexpected at %0t: measurement never ended", $time);
		end
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic t_regs;
		rd(`LPWD_IDX_WUT, `LPWD_WUT_RESET, `LPWD_RESP_OKAY);
		rd(6'h10, 8'h00, `LPWD_RESP_SLVERR);
		wr(6'h10, 8'h55, `LPWD_RESP_SLVERR);
		rd(`LPWD_IDX_CMD, 8'h00, `LPWD_RESP_OKAY);
	endtask
	task automatic t_tune;
		wr(`LPWD_IDX_AAT1, 8'h5A, `LPWD_RESP_OKAY);
		wr(`LPWD_IDX_AAT2, 8'hA5, `LPWD_RESP_OKAY);
		wr(`LPWD_IDX_CFG, 8'h01, `LPWD_RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk(aat_a, `LPWD_AAT_DEFAULT, "tuning a");
		chk(aat_b, `LPWD_AAT_DEFAULT, "tuning b");
		wr(`LPWD_IDX_OP, 8'h80, `LPWD_RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk(aat_a, 8'h5A, "tuning a");
		chk(aat_b, 8'hA5, "tuning b");
		wr(`LPWD_IDX_OP, 8'h84, `LPWD_RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk({7'h00, wake}, 8'h00, "wake with other bits");
		wr(`LPWD_IDX_CFG, 8'h00, `LPWD_RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk(aat_a, 8'h00, "tuning off");
		wr(`LPWD_IDX_OP, 8'h00, `LPWD_RESP_OKAY); // power-down before sensing
	endtask
	task automatic t_meas;
		level <= 8'h6C;
		wr(`LPWD_IDX_CMD, `LPWD_CMD_MEAS_CAP, `LPWD_RESP_OKAY);
		wait_meas;
		rd(`LPWD_IDX_ADC, 8'h6C, `LPWD_RESP_OKAY);
		level <= 8'hFA;
		wr(`LPWD_IDX_CMD, `LPWD_CMD_CAL_CAP, `LPWD_RESP_OKAY);
		wait_meas;
		rd(`LPWD_IDX_CAPD, 8'hFB, `LPWD_RESP_OKAY);
		rd(`LPWD_IDX_CAPC, 8'h1F, `LPWD_RESP_OKAY);
		chk({3'b000, cal_code}, 8'h1F, "calibration code");
		wr(`LPWD_IDX_CAPC, 8'h0A, `LPWD_RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk({3'b000, cal_code}, 8'h0A, "written code");
	endtask
	task automatic t_wake;
		// all setup done before entry
		wr(6'h33, 8'hFA, `LPWD_RESP_OKAY);
		wr(6'h3B, 8'h20, `LPWD_RESP_OKAY);
		wr(6'h3C, 8'h40, `LPWD_RESP_OKAY);
		wr(`LPWD_IDX_WUT, 8'h05, `LPWD_RESP_OKAY);
		level <= 8'h41;
		wr(`LPWD_IDX_OP, `LPWD_OP_WU_ONLY, `LPWD_RESP_OKAY);
		wait_meas;
		chk({7'h00, irq}, 8'h00, "irq within threshold");
		chk({7'h00, wake}, 8'h01, "wake entered");
		rd(6'h35, 8'h41, `LPWD_RESP_OKAY);
		rd(6'h3D, 8'h40, `LPWD_RESP_OKAY);
		rd(6'h3E, 8'h41, `LPWD_RESP_OKAY);
		level <= 8'h4F;
		wait_meas;
		chk({7'h00, irq}, 8'h01, "irq on rise");
		rd(`LPWD_IDX_IRQ, 8'h04, `LPWD_RESP_OKAY);
		rd(6'h35, 8'h48, `LPWD_RESP_OKAY);
		wr(`LPWD_IDX_OP, 8'h00, `LPWD_RESP_OKAY);
		wr(`LPWD_IDX_IRQ, 8'h04, `LPWD_RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk({7'h00, irq}, 8'h00, "irq cleared");
		level <= 8'h30;
		wr(`LPWD_IDX_OP, `LPWD_OP_WU_ONLY, `LPWD_RESP_OKAY);
		wait_meas;
		rd(`LPWD_IDX_IRQ, 8'h05, `LPWD_RESP_OKAY);
		rd(6'h35, 8'h48, `LPWD_RESP_OKAY);
		wr(`LPWD_IDX_OP, 8'h00, `LPWD_RESP_OKAY);
	endtask
	task automatic final_report;
		if (num_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		t_regs;
		t_tune;
		t_meas;
		t_wake;
		final_report;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		$display("unexpected at %0t: run timed out", $time);
		final_report;
	end
endmodule
